//--- i2c_master_model.sv
// upstream bus master model that drives the multiplexer's bus pins
`timescale 1ns/1ps
module i2c_master_model (
    // core clock, used only to pace the pin changes
    input wire logic core_clk,
    // resolved data wire, pulled up
    input wire logic sdaWire,
    // bus clock and released-high data drive
    output logic scl,
    output logic sdaDrv,
    // one-cycle result strobe: ack bit or read byte
    output logic resValid,
    output logic [7:0] resVal
);
    // ------------------------------------------------------------
    // idle bus: both lines high, clock stands still between frames
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
        resValid = 1'b0;
        resVal = 8'h00;
    end
    // pins change only at falling core edges
    task automatic waitN(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // one bit: data moves 3 cycles into the low phase so it is clear of both clock edges
    task automatic bitCyc(input logic b, output logic r);
        scl = 1'b0;
        waitN(3);
        sdaDrv = b;
        waitN(3);
        scl = 1'b1;
        waitN(1);
        r = sdaWire;
        waitN(1);
    endtask
    // start, also usable as repeated start; data falls while clock high
    task automatic startCond();
        scl = 1'b0;
        waitN(3);
        sdaDrv = 1'b1;
        waitN(3);
        scl = 1'b1;
        waitN(4);
        sdaDrv = 1'b0;
        waitN(4);
    endtask
    // stop: data rises while clock high, then both lines left high
    task automatic stopCond();
        scl = 1'b0;
        waitN(3);
        sdaDrv = 1'b0;
        waitN(3);
        scl = 1'b1;
        waitN(4);
        sdaDrv = 1'b1;
        waitN(4);
    endtask
    // hand a result to the bench for one cycle
    task automatic post(input logic [7:0] v);
        resVal = v;
        resValid = 1'b1;
        waitN(1);
        resValid = 1'b0;
    endtask
    // send a byte msb first, data released during the ack clock
    task automatic sendByte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitCyc(d[i], r);
        end
        bitCyc(1'b1, r);
        post({7'h00, r});
    endtask
    // receive a byte; ackBit high means no ack on the last byte
    task automatic recvByte(input logic ackBit);
        logic [7:0] v;
        logic r;
        for (int i = 0; i < 8; i++) begin
            bitCyc(1'b1, r);
            v = {v[6:0], r};
        end
        bitCyc(ackBit, r);
        post(v);
    endtask
endmodule

//--- i2c_two_channel_mux_ctrl.sv
// control logic of a one-of-two bus multiplexer with interrupt collection
`timescale 1ns/1ps
module i2c_two_channel_mux_ctrl
    import mux_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // upstream bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic addr_sel_bit0,
    input wire logic addr_sel_bit1,
    input wire logic addr_sel_bit2,
    // channel interrupt inputs, active low
    input wire logic chan0_irq_in_n,
    input wire logic chan1_irq_in_n,
    // interrupt output, open drain
    output logic irq_out,
    output logic irq_oe,
    // downstream pair connect controls
    output logic down0_connect,
    output logic down1_connect
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sclLvl; // synchronised clock line
    logic sclRise; // clock rising edge
    logic sclFall; // clock falling edge
    logic sdaLvl; // synchronised data line
    logic sdaRise; // data rising edge
    logic sdaFall; // data falling edge

    sync_edge u_scl_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(scl_in),
        .level(sclLvl),
        .rise(sclRise),
        .fall(sclFall)
    );

    sync_edge u_sda_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(sda_in),
        .level(sdaLvl),
        .rise(sdaRise),
        .fall(sdaFall)
    );

    // interrupt inputs and straps pass two flops too
    logic [1:0] irqMeta_reg; // first stage only
    logic [1:0] irqSync_reg; // synchronised inputs, active low
    logic [2:0] addrMeta_reg; // first stage only
    logic [2:0] addrSync_reg; // synchronised straps

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqMeta_reg <= 2'h3;
            irqSync_reg <= 2'h3;
        end else begin
            irqMeta_reg <= {chan1_irq_in_n, chan0_irq_in_n};
            irqSync_reg <= irqMeta_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addrMeta_reg <= 3'h0;
            addrSync_reg <= 3'h0;
        end else begin
            addrMeta_reg <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
            addrSync_reg <= addrMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // start and stop detection
    // ------------------------------------------------------------
    logic startDet; // data falls while clock high
    logic stopDet; // data rises while clock high
    assign startDet = sdaFall & sclLvl;
    assign stopDet = sdaRise & sclLvl;

    // ------------------------------------------------------------
    // bus engine state
    // ------------------------------------------------------------
    bus_state_t state_reg; // engine state
    logic [3:0] bitCnt_reg; // bit index within a byte
    logic [7:0] shift_reg; // receive shift register
    logic [7:0] txByte_reg; // byte being sent on read
    logic [7:0] ctrl_reg; // stored selection bits
    logic [2:0] pending_reg; // selection waiting for stop
    logic [2:0] active_reg; // selection in force
    logic ackDrive_reg; // pull data low for acknowledge
    logic txDrive_reg; // pull data low for a zero bit
    logic isRead_reg; // current transfer direction

    // address match against straps
    function automatic logic addrHit(input logic [7:0] b, input logic [2:0] s);
        addrHit = (b[7:4] == SLAVE_ADDR_HI) && (b[3:1] == s);
    endfunction

    // live status byte returned on read
    function automatic logic [7:0] readByte(input logic [7:0] c, input logic [1:0] n);
        readByte = (c & STORE_MASK)
            | {2'b00, ~n[1], ~n[0], 4'h0};
    endfunction

    // ------------------------------------------------------------
    // protocol engine, advances on clock edges of the bus
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            isRead_reg <= 1'b0;
        end else if (startDet) begin
            // repeated start is legal anywhere
            state_reg <= ST_ADDR;
            bitCnt_reg <= 4'h0;
        end else if (stopDet) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_ADDR, ST_WR_DATA: begin
                    if (sclRise) begin
                        shift_reg <= {shift_reg[6:0], sdaLvl};
                    end
                    if (sclFall && bitCnt_reg == BYTE_LAST + 4'h1) begin
                        bitCnt_reg <= 4'h0;
                        if (state_reg == ST_WR_DATA) begin
                            state_reg <= ST_WR_ACK;
                        end else if (addrHit(shift_reg, addrSync_reg)) begin
                            state_reg <= ST_ADDR_ACK;
                            isRead_reg <= shift_reg[0];
                        end else begin
                            state_reg <= ST_IDLE; // other address, stay off bus
                        end
                    end else if (sclRise) begin
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (sclFall) begin
                        state_reg <= isRead_reg ? ST_RD_DATA : ST_WR_DATA;
                    end
                end
                ST_RD_DATA: begin
                    if (sclFall) begin
                        if (bitCnt_reg == BYTE_LAST) begin
                            bitCnt_reg <= 4'h0;
                            state_reg <= ST_RD_ACK;
                        end else begin
                            bitCnt_reg <= bitCnt_reg + 4'h1;
                        end
                    end
                end
                ST_RD_ACK: begin
                    // master nack ends reading; ack asks for another byte
                    if (sclRise && sdaLvl) begin
                        state_reg <= ST_IDLE;
                    end else if (sclFall) begin
                        state_reg <= ST_RD_DATA;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register: each written byte replaces the last
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (state_reg == ST_WR_DATA && sclFall && bitCnt_reg == BYTE_LAST + 4'h1) begin
            // status and top bits are accepted but not kept
            ctrl_reg <= shift_reg & STORE_MASK;
        end
    end

    // ------------------------------------------------------------
    // selection waits for stop so lines are idle when joined
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pending_reg <= 3'h0;
            active_reg <= 3'h0;
        end else begin
            pending_reg <= ctrl_reg[2:0];
            if (stopDet) begin
                active_reg <= pending_reg;
            end
        end
    end

    // only enable set and mid clear selects a pair
    assign down0_connect = active_reg[CHAN_ENABLE_POS] & ~active_reg[CHAN_MID_POS]
        & ~active_reg[CHAN_PICK_POS];
    assign down1_connect = active_reg[CHAN_ENABLE_POS] & ~active_reg[CHAN_MID_POS]
        & active_reg[CHAN_PICK_POS];

    // ------------------------------------------------------------
    // transmit byte captured as a read starts
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txByte_reg <= 8'h00;
        end else if ((state_reg == ST_ADDR_ACK || state_reg == ST_RD_ACK) && sclFall) begin
            txByte_reg <= readByte(ctrl_reg, irqSync_reg);
        end else if (state_reg == ST_RD_DATA && sclFall) begin
            txByte_reg <= {txByte_reg[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // data line drive, changed only while the clock is low
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ackDrive_reg <= 1'b0;
            txDrive_reg <= 1'b0;
        end else begin
            ackDrive_reg <= (state_reg == ST_ADDR_ACK || state_reg == ST_WR_ACK) && !startDet && !stopDet;
            txDrive_reg <= state_reg == ST_RD_DATA && !txByte_reg[7] && !startDet && !stopDet;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = ackDrive_reg | txDrive_reg;

    // ------------------------------------------------------------
    // interrupt output, independent of selection
    // ------------------------------------------------------------
    logic irqLow_reg; // output pulled low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqLow_reg <= 1'b0;
        end else begin
            irqLow_reg <= ~(irqSync_reg[0] & irqSync_reg[1]);
        end
    end
    assign irq_out = 1'b0;
    assign irq_oe = irqLow_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_irq_and_inputs: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq_oe == $past(~(irqSync_reg[0] & irqSync_reg[1])))
        else $error("interrupt output not AND of inputs");
    a_sel_at_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(stopDet) |-> $stable(active_reg))
        else $error("selection changed without stop");
    a_never_both: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(down0_connect && down1_connect))
        else $error("both channels connected");
    a_top_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        txByte_reg[7:6] == 2'b00 || state_reg == ST_RD_DATA)
        else $error("top bits not zero");
    a_store_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_reg[7:4] == 4'h0)
        else $error("status bits were stored");
    a_wr_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_WR_DATA && sclFall && bitCnt_reg == 4'h8)
        |=> ctrl_reg == ($past(shift_reg) & STORE_MASK))
        else $error("written byte not stored");
    a_sel_low_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(stopDet) |-> active_reg == $past(pending_reg))
        else $error("selection not from pending bits");
    a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_ADDR_ACK && sclFall && !startDet && !stopDet)
        |=> txByte_reg[5:4] == ~$past(irqSync_reg))
        else $error("status not captured on read");
    a_reset_idle: assert property (@(posedge core_clk)
        !rst_n |=> state_reg == ST_IDLE && active_reg == 3'h0)
        else $error("reset did not clear state");
    // a matching address pulls the line one cycle after the ack state opens
    a_addr_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_ADDR && sclFall && bitCnt_reg == 4'h8 && addrHit(shift_reg, addrSync_reg))
        |=> ##1 sda_oe)
        else $error("matching address not acknowledged");
    // a foreign address never pulls the line
    a_addr_foreign: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_ADDR && sclFall && bitCnt_reg == 4'h8 && !addrHit(shift_reg, addrSync_reg))
        |=> ##1 !sda_oe)
        else $error("foreign address acknowledged");
    // master nack ends the read and frees the line for its stop
    a_rd_nack: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_RD_ACK && sclRise && sdaLvl && !startDet && !stopDet)
        |=> state_reg == ST_IDLE ##1 !sda_oe)
        else $error("read not ended on nack");
    // connect pins move only right after a stop
    a_pins_at_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(stopDet) |-> $stable(down0_connect) && $stable(down1_connect))
        else $error("connect pins changed without stop");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    // one per scenario: write, read, each pair joined, interrupt
    c_write: cover property (@(posedge core_clk) state_reg == ST_WR_ACK);
    c_read: cover property (@(posedge core_clk) state_reg == ST_RD_ACK);
    c_chan1: cover property (@(posedge core_clk) down1_connect);
    c_irq: cover property (@(posedge core_clk) irq_oe);
    c_chan0: cover property (@(posedge core_clk) down0_connect);
endmodule

//--- i2c_two_channel_mux_ctrl_tb.sv
// self-checking bench for the two-channel multiplexer control block
`timescale 1ns/1ps
module i2c_two_channel_mux_ctrl_tb;
    import mux_ctrl_pkg::*;
    logic core_clk, rst_n, scl, sdaDrv, sdaWire, resValid;
    logic [7:0] resVal;
    logic [2:0] straps; // address straps, random from a fixed seed
    logic chan0IrqN, chan1IrqN;
    logic sdaOut, sdaOe, irqOut, irqOe, down0, down1;
    logic [7:0] expQ[$]; // expected bus results, oldest first
    logic [3:0] stored; // low nibble the register should hold
    logic [1:0] conn; // expected {pair one, pair zero} connect
    logic [6:0] devAddr;
    logic [7:0] rnd;
    int errors, testsRun;
    // wire level: pulled up, low if either party pulls
    assign sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    assign devAddr = {SLAVE_ADDR_HI, straps};
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    i2c_two_channel_mux_ctrl i2c_two_channel_mux_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sdaWire), .sda_out(sdaOut), .sda_oe(sdaOe), .addr_sel_bit0(straps[0]), .addr_sel_bit1(straps[1]),
        .addr_sel_bit2(straps[2]), .chan0_irq_in_n(chan0IrqN), .chan1_irq_in_n(chan1IrqN), .irq_out(irqOut),
        .irq_oe(irqOe), .down0_connect(down0), .down1_connect(down1));
    i2c_master_model i2c_master_model_i (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv),
        .resValid(resValid), .resVal(resVal));
    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic stopTest();
        if (errors == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // pair decode: enable set and middle bit clear picks a pair
    function automatic logic [1:0] selOf(input logic [3:0] s);
        return (s[2] && !s[1]) ? (s[0] ? 2'b10 : 2'b01) : 2'b00;
    endfunction
    // result watcher: each strobe consumes the oldest note
    always @(posedge core_clk) begin
        if (resValid === 1'b1) begin
            if (expQ.size() == 0) begin
                errors++;
                $display("[ERR] bus result exp none got %h", resVal);
            end else begin
                chk("bus result", expQ.pop_front(), resVal);
            end
        end
    end
    task automatic chkConn(input string name);
        chk(name, {6'h00, conn}, {6'h00, down1, down0});
    endtask
    // ------------------------------------------------------------
    // bus transfers
    // ------------------------------------------------------------
    // address always goes first after start; a foreign address gets no ack
    task automatic writeReg(input logic [6:0] a, input logic [7:0] d, input bit more, input logic [7:0] d2);
        expQ.push_back({7'h00, a != devAddr});
        i2c_master_model_i.startCond();
        i2c_master_model_i.sendByte({a, 1'b0});
        if (a == devAddr) begin
            expQ.push_back(8'h00);
            i2c_master_model_i.sendByte(d);
            if (more) begin
                expQ.push_back(8'h00);
                i2c_master_model_i.sendByte(d2);
            end
            stored = more ? d2[3:0] : d[3:0];
        end
        repeat (8) @(negedge core_clk);
        chkConn("connect before stop");
        i2c_master_model_i.stopCond();
        repeat (8) @(negedge core_clk);
        conn = selOf(stored);
        chkConn("connect after stop");
    endtask
    // read the register, master refuses the single byte before stop
    task automatic readReg();
        expQ.push_back(8'h00);
        expQ.push_back({2'b00, !chan1IrqN, !chan0IrqN, stored});
        i2c_master_model_i.startCond();
        i2c_master_model_i.sendByte({devAddr, 1'b1});
        i2c_master_model_i.recvByte(1'b1);
        i2c_master_model_i.stopCond();
        repeat (8) @(negedge core_clk);
    endtask
    task automatic doReset();
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        stored = 4'h0;
        conn = 2'b00;
        chkConn("connect after reset");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        testsRun = 0;
        void'($urandom(32'h01ef0b20));
        straps = 3'($urandom);
        chan0IrqN = 1'b1;
        chan1IrqN = 1'b1;
        rst_n = 1'b0;
        doReset();
        chk("irq after reset", 8'h01, {7'h00, irqOe ? irqOut : 1'b1});
        readReg();
        // pair zero, then a burst where the last byte wins and top bits are dropped
        writeReg(devAddr, 8'h04, 1'b0, 8'h00);
        rnd = 8'($urandom);
        writeReg(devAddr, 8'h04, 1'b1, {rnd[7:4], 4'hd});
        readReg();
        // every selection code, random upper bits ignored for the pair choice
        for (int v = 0; v < 8; v++) begin
            rnd = 8'($urandom);
            writeReg(devAddr, {rnd[7:3], 3'(v)}, 1'b0, 8'h00);
        end
        // foreign address: ignored, register keeps its value
        writeReg(devAddr ^ {4'h0, 3'(1 + $urandom % 7)}, 8'h04, 1'b0, 8'h00);
        readReg();
        // all interrupt combinations, with no pair and then pair zero selected
        for (int k = 0; k < 8; k++) begin
            if (k == 4)
                writeReg(devAddr, 8'h04, 1'b0, 8'h00);
            chan0IrqN = k[0];
            chan1IrqN = k[1];
            repeat (6) @(negedge core_clk);
            chk("irq pin", {7'h00, k[0] && k[1]}, {7'h00, irqOe ? irqOut : 1'b1});
            readReg();
        end
        // reset in mid-run clears the selection again
        doReset();
        readReg();
        chk("pending results", 8'h00, 8'(expQ.size()));
        stopTest();
    end
    // watchdog well beyond the expected run length
    initial begin
        #200000;
        errors++;
        stopTest();
    end
endmodule

//--- mux_ctrl_pkg.sv
// constants for the two-channel bus multiplexer control block
package mux_ctrl_pkg;
    // fixed upper four bits of the seven-bit slave address
    localparam logic [3:0] SLAVE_ADDR_HI = 4'he;
    // control register reset value
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // field positions in the control byte
    localparam int CHAN_PICK_POS = 0;
    localparam int CHAN_MID_POS = 1;
    localparam int CHAN_ENABLE_POS = 2;
    localparam int CHAN0_IRQ_POS = 4;
    localparam int CHAN1_IRQ_POS = 5;
    // bits kept in storage: selection plus unused bit three
    localparam logic [7:0] STORE_MASK = 8'h0f;
    // bit counter width and last bit index of a byte
    localparam logic [3:0] BYTE_LAST = 4'h7;
    // bus engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK
    } bus_state_t;
endpackage

//--- sync_edge.sv
// two-flop synchroniser with edge flags for one pin
`timescale 1ns/1ps
module sync_edge
    import mux_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // asynchronous pin
    input wire logic pinIn,
    // synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_reg; // first stage, read only by the second
    logic sync_reg; // second stage
    logic prev_reg; // delayed copy for edge detection

    // ------------------------------------------------------------
    // synchroniser, resets to idle-high bus level
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
endmodule
